// >>> src/sph_consts.svh
// Offsets, field positions and reset values of the strobed port handshake block
`ifndef SPH_CONSTS_SVH
`define SPH_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------------------------------------
`define SPH_ADDR_CTRL   8'h00
`define SPH_ADDR_PORTA  8'h04
`define SPH_ADDR_PORTB  8'h08
`define SPH_ADDR_PORTC  8'h0C
`define SPH_ADDR_BSR    8'h10

// ----------------------------------------------------------------------
// Control register fields (1 = input)
// ----------------------------------------------------------------------
`define SPH_CTRL_A_IN   0
`define SPH_CTRL_B_IN   1
`define SPH_CTRL_CU_IN  3
`define SPH_CTRL_RST    8'h0B

// ----------------------------------------------------------------------
// Port C bit positions
// ----------------------------------------------------------------------
`define SPH_PC_INTRB    0
`define SPH_PC_BFB      1
`define SPH_PC_HSB      2
`define SPH_PC_INTRA    3
`define SPH_PC_STBA     4
`define SPH_PC_IBFA     5
`define SPH_PC_ACKA     6
`define SPH_PC_OBFA     7
`define SPH_PCREG_RST   8'h00

// ----------------------------------------------------------------------
// Bit set/reset command fields
// ----------------------------------------------------------------------
`define SPH_BSR_SET     0
`define SPH_BSR_SEL_LO  1
`define SPH_BSR_SEL_HI  3

// ----------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------
`define SPH_HSIZE_WORD  3'h2
`define SPH_HRESP_OKAY  1'b0

`endif

// >>> src/sph_pkg.sv
// Types shared by the strobed port handshake block
`include "sph_consts.svh"

package sph_pkg;

   // ----------------------------------------------------------------------
   // Bus slave states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      SPH_ST_IDLE = 3'b001,
      SPH_ST_DATA = 3'b010,
      SPH_ST_RESP = 3'b100
   } sph_bus_st_t;

   // ----------------------------------------------------------------------
   // One strobed data port
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] in_q;
      logic [7:0] out_q;
      logic       ibf;
      logic       obf_n;
      logic       intr;
   } sph_port_t;

   localparam sph_port_t SPH_PORT_RST = '{in_q: 8'h00, out_q: 8'h00, ibf: 1'b0,
                                          obf_n: 1'b1, intr: 1'b0};

endpackage : sph_pkg

// >>> src/sph_edge_sense.sv
// Strobe sampler that reports registered rising and falling edges
`timescale 1ns/10ps
`default_nettype none

module sph_edge_sense #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] sig,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   import sph_pkg::*;

   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } sph_edge_state_t;

   sph_edge_state_t q;
   sph_edge_state_t d;

   // Strobes idle high, so a strobe held low through reset shows a fall once reset ends
   always_comb begin
      d      = q;
      d.prev = sig;
      d.rise = ~q.prev & sig;   // RULE_21
      d.fall = q.prev & ~sig;   // RULE_21
   end

   // Strobes shorter than one clock can be missed entirely
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{prev: {W{1'b1}}, rise: {W{1'b0}}, fall: {W{1'b0}}};
      end else begin
         q <= d;   // RULE_18
      end
   end

   assign rise = q.rise;
   assign fall = q.fall;

endmodule : sph_edge_sense

`default_nettype wire

// >>> src/sph_strobed_port.sv
// Strobed handshake logic for two data ports, with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none

`include "sph_consts.svh"

// How it works
// RULE_01: Ports A and B are data ports, each set as input or output alone.
// RULE_02: Input and output data are registered; three port C lines serve each port.
// RULE_03: While the load strobe is low, the input register follows the port pins.
// RULE_04: Input-full flag sets when load strobe falls, clears when CPU read ends.
// RULE_05: Load strobe rising sets the input port interrupt if its enable is 1.
// RULE_06: Start of a CPU read of an input port clears its interrupt.
// RULE_07: Input mode enables are bit-set on PC4 for port A, PC2 for port B.
// RULE_08: End of a CPU write to an output port drives its full flag low.
// RULE_09: Peripheral acknowledge low returns the output full flag high.
// RULE_10: Peripheral should latch output data on the full flag's rising edge.
// RULE_11: Peripheral asserts acknowledge low when ready to take output data.
// RULE_12: Start of a CPU write to an output port clears its interrupt.
// RULE_13: Acknowledge rising sets the output port interrupt if its enable is 1.
// RULE_14: Output mode enables are bit-set on PC6 for port A, PC2 for port B.
// RULE_15: Interrupt enables live in the port C output register at PC2, PC4, PC6.
// RULE_16: PC0 port B interrupt, PC1 port B flag, PC2 port B strobe, PC3 port A interrupt.
// RULE_17: Port A uses PC4-5 or PC6-7; the spare pair's direction is control bit 3.
// RULE_18: Every strobe must stay asserted for at least one clock cycle.
// RULE_19: A byte write to port C changes nothing; only bit set/reset does.
// RULE_20: Reading port C returns flags, interrupts and enables as status.
// RULE_21: Strobes are sampled on the clock; each edge acts the cycle after detection.
// RULE_22: Reset clears interrupts and enables; input-full to 0, output-full-low to 1.
module sph_strobed_port (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Port A pins
   input  wire logic [7:0]  pa_in,
   output logic      [7:0]  pa_out,
   output logic      [7:0]  pa_oe,
   // Port B pins
   input  wire logic [7:0]  pb_in,
   output logic      [7:0]  pb_out,
   output logic      [7:0]  pb_oe,
   // Port C pins
   input  wire logic [7:0]  pc_in,
   output logic      [7:0]  pc_out,
   output logic      [7:0]  pc_oe
);
   import sph_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      sph_bus_st_t st;
      logic [7:0]  addr;
      logic        wr;
      logic        ok;
      logic [31:0] rdata;
      logic [7:0]  ctrl;
      logic [7:0]  pcreg;
      sph_port_t   pa;
      sph_port_t   pb;
   } sph_state_t;

   localparam sph_state_t STATE_RST = '{st: SPH_ST_IDLE, addr: 8'h00, wr: 1'b0, ok: 1'b0,
                                        rdata: 32'h0000_0000, ctrl: `SPH_CTRL_RST,
                                        pcreg: `SPH_PCREG_RST, pa: SPH_PORT_RST,
                                        pb: SPH_PORT_RST};

   sph_state_t q;
   sph_state_t d;

   logic [1:0] rst_sync_q;
   logic       rst_s_n;
   logic [2:0] hs_rise;
   logic [2:0] hs_fall;

   // ----------------------------------------------------------------------
   // One step of a port's handshake flags
   // ----------------------------------------------------------------------
   function automatic sph_port_t port_step(
      input sph_port_t  p,
      input logic       is_in,
      input logic [7:0] pins,
      input logic       stb_lo,
      input logic       stb_fall,
      input logic       stb_rise,
      input logic       ack_lo,
      input logic       ack_rise,
      input logic       inte,
      input logic       rd_fall,
      input logic       rd_rise,
      input logic       wr_fall,
      input logic       wr_rise,
      input logic [7:0] wdata
   );
      sph_port_t n;
      n = p;
      // Output register is kept even in input mode, so a later turn-round shows it
      if (wr_rise) begin
         n.out_q = wdata;   // RULE_02
      end
      if (is_in) begin
         if (stb_lo) begin
            n.in_q = pins;   // RULE_03
         end
         if (rd_rise) begin
            n.ibf = 1'b0;   // RULE_04
         end
         if (stb_fall) begin
            n.ibf = 1'b1;   // RULE_04
         end
         if (rd_fall) begin
            n.intr = 1'b0;   // RULE_06
         end
         if (stb_rise && inte) begin
            n.intr = 1'b1;   // RULE_05
         end
      end else begin
         if (ack_lo) begin
            n.obf_n = 1'b1;   // RULE_09 RULE_11
         end
         // A new write wins over an acknowledge in the same cycle
         if (wr_rise) begin
            n.obf_n = 1'b0;   // RULE_08
         end
         if (wr_fall) begin
            n.intr = 1'b0;   // RULE_12
         end
         if (ack_rise && inte) begin
            n.intr = 1'b1;   // RULE_13
         end
      end
      return n;
   endfunction : port_step

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_s_n = rst_sync_q[1];

   // ----------------------------------------------------------------------
   // Strobe edges: bit 2 port A acknowledge, bit 1 port A load, bit 0 port B
   // ----------------------------------------------------------------------
   sph_edge_sense #(
      .W (3)
   ) u_edge (
      .clk   (sys_clk),
      .rst_n (rst_s_n),
      .sig   ({pc_in[`SPH_PC_ACKA], pc_in[`SPH_PC_STBA], pc_in[`SPH_PC_HSB]}),
      .rise  (hs_rise),
      .fall  (hs_fall)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic       a_in;
      logic       b_in;
      logic       cu_in;
      logic       take;
      logic       rd_a;
      logic       rd_b;
      logic       wr_a;
      logic       wr_b;
      logic       inte_a;
      logic       inte_b;
      logic [7:0] status;
      logic [7:0] rval;
      logic [2:0] sel;

      d      = q;
      a_in   = q.ctrl[`SPH_CTRL_A_IN];   // RULE_01
      b_in   = q.ctrl[`SPH_CTRL_B_IN];   // RULE_01
      cu_in  = q.ctrl[`SPH_CTRL_CU_IN];
      take   = hsel && htrans[1] && hready;
      inte_a = a_in ? q.pcreg[`SPH_PC_STBA] : q.pcreg[`SPH_PC_ACKA];   // RULE_15
      inte_b = q.pcreg[`SPH_PC_HSB];   // RULE_15
      sel    = hwdata[`SPH_BSR_SEL_HI:`SPH_BSR_SEL_LO];

      // The one data-phase cycle with hreadyout low stands for the CPU strobe
      // low time: its start and its end both act in that cycle.
      rd_a = (q.st == SPH_ST_DATA) && q.ok && !q.wr && (q.addr == `SPH_ADDR_PORTA);
      rd_b = (q.st == SPH_ST_DATA) && q.ok && !q.wr && (q.addr == `SPH_ADDR_PORTB);
      wr_a = (q.st == SPH_ST_DATA) && q.ok && q.wr && (q.addr == `SPH_ADDR_PORTA);
      wr_b = (q.st == SPH_ST_DATA) && q.ok && q.wr && (q.addr == `SPH_ADDR_PORTB);

      // Port C status as the directions place it
      status                = 8'h00;
      status[`SPH_PC_INTRB] = q.pb.intr;   // RULE_20
      status[`SPH_PC_BFB]   = b_in ? q.pb.ibf : q.pb.obf_n;
      status[`SPH_PC_HSB]   = inte_b;
      status[`SPH_PC_INTRA] = q.pa.intr;
      if (a_in) begin
         status[`SPH_PC_STBA] = inte_a;
         status[`SPH_PC_IBFA] = q.pa.ibf;
         status[7:6]          = cu_in ? pc_in[7:6] : q.pcreg[7:6];
      end else begin
         status[5:4]          = cu_in ? pc_in[5:4] : q.pcreg[5:4];
         status[`SPH_PC_ACKA] = inte_a;
         status[`SPH_PC_OBFA] = q.pa.obf_n;
      end

      // Read multiplexer
      rval = 8'h00;
      if (q.ok) begin
         unique case (q.addr)
            `SPH_ADDR_CTRL:  rval = q.ctrl;
            `SPH_ADDR_PORTA: rval = a_in ? q.pa.in_q : q.pa.out_q;
            `SPH_ADDR_PORTB: rval = b_in ? q.pb.in_q : q.pb.out_q;
            `SPH_ADDR_PORTC: rval = status;   // RULE_20
            default:         rval = 8'h00;
         endcase
      end

      // Bus slave sequence
      unique case (q.st)
         SPH_ST_IDLE, SPH_ST_RESP: begin
            if (take) begin
               d.st   = SPH_ST_DATA;
               d.addr = haddr[7:0];
               d.wr   = hwrite;
               d.ok   = (hsize == `SPH_HSIZE_WORD) && (haddr[31:8] == 24'h00_0000);
            end else begin
               d.st = SPH_ST_IDLE;
            end
         end
         SPH_ST_DATA: begin
            d.st    = SPH_ST_RESP;
            d.rdata = {24'h00_0000, rval};
            if (q.ok && q.wr) begin
               unique case (q.addr)
                  `SPH_ADDR_CTRL: d.ctrl = hwdata[7:0];
                  // Byte writes to port C are dropped in this mode
                  `SPH_ADDR_PORTC: d.pcreg = q.pcreg;   // RULE_19
                  `SPH_ADDR_BSR: d.pcreg[sel] = hwdata[`SPH_BSR_SET];   // RULE_07 RULE_14
                  default: d.pcreg = q.pcreg;
               endcase
            end
         end
         default: begin
            d.st = SPH_ST_IDLE;
         end
      endcase

      // Handshake flags of both ports
      d.pa = port_step(q.pa, a_in, pa_in,
                       !pc_in[`SPH_PC_STBA], hs_fall[1], hs_rise[1],
                       !pc_in[`SPH_PC_ACKA], hs_rise[2], inte_a,
                       rd_a, rd_a, wr_a, wr_a, hwdata[7:0]);   // RULE_21
      d.pb = port_step(q.pb, b_in, pb_in,
                       !pc_in[`SPH_PC_HSB], hs_fall[0], hs_rise[0],
                       !pc_in[`SPH_PC_HSB], hs_rise[0], inte_b,
                       rd_b, rd_b, wr_b, wr_b, hwdata[7:0]);   // RULE_21
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         q <= STATE_RST;   // RULE_22
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Bus outputs
   // ----------------------------------------------------------------------
   assign hrdata    = q.rdata;
   assign hreadyout = (q.st != SPH_ST_DATA);
   assign hresp     = `SPH_HRESP_OKAY;

   // ----------------------------------------------------------------------
   // Data port pins
   // ----------------------------------------------------------------------
   assign pa_out = q.pa.out_q;   // RULE_02
   assign pb_out = q.pb.out_q;   // RULE_02
   assign pa_oe  = q.ctrl[`SPH_CTRL_A_IN] ? 8'h00 : 8'hFF;   // RULE_01
   assign pb_oe  = q.ctrl[`SPH_CTRL_B_IN] ? 8'h00 : 8'hFF;   // RULE_01

   // ----------------------------------------------------------------------
   // Port C pins
   // ----------------------------------------------------------------------
   always_comb begin
      logic a_in;
      logic spare_oe;
      a_in     = q.ctrl[`SPH_CTRL_A_IN];
      spare_oe = !q.ctrl[`SPH_CTRL_CU_IN];   // RULE_17
      pc_out   = q.pcreg;
      pc_oe    = 8'h00;

      pc_out[`SPH_PC_INTRB] = q.pb.intr;   // RULE_16
      pc_out[`SPH_PC_BFB]   = q.ctrl[`SPH_CTRL_B_IN] ? q.pb.ibf : q.pb.obf_n;   // RULE_16
      pc_out[`SPH_PC_INTRA] = q.pa.intr;   // RULE_16
      pc_oe[`SPH_PC_INTRB]  = 1'b1;   // RULE_16
      pc_oe[`SPH_PC_BFB]    = 1'b1;   // RULE_16
      pc_oe[`SPH_PC_HSB]    = 1'b0;   // RULE_16
      pc_oe[`SPH_PC_INTRA]  = 1'b1;   // RULE_16

      if (a_in) begin
         pc_out[`SPH_PC_IBFA] = q.pa.ibf;   // RULE_17
         pc_oe[`SPH_PC_STBA]  = 1'b0;   // RULE_17
         pc_oe[`SPH_PC_IBFA]  = 1'b1;   // RULE_17
         pc_oe[7:6]           = {2{spare_oe}};   // RULE_17
      end else begin
         pc_out[`SPH_PC_OBFA] = q.pa.obf_n;   // RULE_17
         pc_oe[5:4]           = {2{spare_oe}};   // RULE_17
         pc_oe[`SPH_PC_ACKA]  = 1'b0;   // RULE_17
         pc_oe[`SPH_PC_OBFA]  = 1'b1;   // RULE_17
      end
   end

endmodule : sph_strobed_port

`default_nettype wire

// >>> tb/sph_strobed_port_assertions.sv
// Concurrent checks on the pins of the strobed port handshake block
`timescale 1ns/10ps
`default_nettype none
`include "sph_consts.svh"

module sph_strobed_port_chk (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [7:0]  pa_oe,
   input wire logic [7:0]  pb_oe,
   input wire logic [7:0]  pb_out,
   input wire logic [7:0]  pc_in,
   input wire logic [7:0]  pc_out,
   input wire logic [7:0]  pc_oe
);
   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   logic taken;
   logic a_in;
   logic b_out;
   assign taken = hsel && htrans[1] && hready;
   assign a_in  = (pa_oe == 8'h00);
   assign b_out = (pb_oe == 8'hFF);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   ibf_set_a : assert property (a_in && $fell(pc_in[4]) |-> ##2 pc_out[5])
      else $error("input full flag late");
   intr_load_a : assert property (a_in && pc_out[4] && $rose(pc_in[4]) |-> ##2 pc_out[3])
      else $error("input interrupt not raised");
   intr_masked_a : assert property (a_in && !pc_out[4] && !pc_out[3] && $rose(pc_in[4])
      |-> ##2 !pc_out[3])
      else $error("masked interrupt raised");
   rd_clear_a : assert property (taken && !hwrite && haddr == {24'h00_0000, `SPH_ADDR_PORTA}
      && a_in |-> ##2 (!pc_out[5] && !pc_out[3]))
      else $error("read left flags set");
   obf_write_a : assert property (taken && hwrite && haddr == {24'h00_0000, `SPH_ADDR_PORTB}
      && b_out |-> ##2 (!pc_out[1] && !pc_out[0] && pb_out == $past(hwdata[7:0])))
      else $error("output write effects wrong");
   ack_return_a : assert property (b_out && !pc_in[2] && !pc_out[1] |-> ##[1:2] pc_out[1])
      else $error("output full flag stuck low");
   intr_ack_a : assert property (b_out && pc_out[2] && $rose(pc_in[2]) |-> ##2 pc_out[0])
      else $error("output interrupt not raised");
   pc_dir_a : assert property (a_in |-> pc_oe[5:0] == 6'h2B)
      else $error("port C direction wrong");
   hready_wait_a : assert property (taken |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
endmodule : sph_strobed_port_chk

bind sph_strobed_port sph_strobed_port_chk u_sph_strobed_port_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .pa_oe(pa_oe), .pb_oe(pb_oe), .pb_out(pb_out), .pc_in(pc_in), .pc_out(pc_out),
   .pc_oe(pc_oe));
`default_nettype wire

// >>> tb/sph_periph_model.sv
// Behavioural peripheral on the far side of ports A and B
`timescale 1ns/10ps
`default_nettype none

module sph_periph_model (
   input  wire logic       sys_clk,
   input  wire logic       load_go,
   input  wire logic [7:0] load_byte,
   input  wire logic [3:0] ack_dly,
   input  wire logic       armed,
   input  wire logic       obf_n,
   input  wire logic [7:0] out_byte,
   output logic            stb_n,
   output logic            ack_n,
   output logic      [7:0] data,
   output logic      [7:0] got
);
   logic obf_q;
   initial begin
      stb_n = 1'b1;
      ack_n = 1'b1;
      data  = 8'h00;
      got   = 8'h00;
      obf_q = 1'b1;
   end
   // Bus shows the inverse one clock after the strobe ends, so stale data never passes
   always begin
      @(posedge sys_clk);
      if (load_go) begin
         data  <= load_byte;
         stb_n <= 1'b0;
         repeat (3) @(posedge sys_clk);
         stb_n <= 1'b1;
         @(posedge sys_clk);
         data  <= ~load_byte;
      end
   end
   always begin
      @(posedge sys_clk);
      if (armed && !obf_n && ack_n) begin
         repeat (ack_dly) @(posedge sys_clk);
         ack_n <= 1'b0;
         repeat (2) @(posedge sys_clk);
         ack_n <= 1'b1;
         @(posedge sys_clk);
      end
   end
   always @(posedge sys_clk) begin
      obf_q <= obf_n;
      if (obf_n && !obf_q) got <= out_byte;
   end
endmodule : sph_periph_model
`default_nettype wire

// >>> tb/sph_strobed_port_tb.sv
// Self-checking bench for the strobed port handshake block
`timescale 1ns/10ps
`default_nettype none
`include "sph_consts.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module sph_strobed_port_tb;
   typedef struct { logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e; } sph_row_t;
   logic        sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic        stb_n, ack_n, load_go;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  ack_dly;
   logic [7:0]  pa_in, pa_out, pa_oe, pb_out, pb_oe, pc_in, pc_out, pc_oe, got, load_byte, ob;
   int          n_errors, num_checks;
   sph_row_t    rows [8] = '{
      '{`SPH_ADDR_CTRL,  1'b0, 8'h00, 8'h0B}, '{`SPH_ADDR_CTRL,  1'b1, 8'h09, 8'h00},
      '{`SPH_ADDR_CTRL,  1'b0, 8'h00, 8'h09}, '{`SPH_ADDR_BSR,   1'b1, 8'h09, 8'h00},
      '{`SPH_ADDR_BSR,   1'b1, 8'h05, 8'h00}, '{`SPH_ADDR_PORTC, 1'b1, 8'hFF, 8'h00},
      '{`SPH_ADDR_PORTC, 1'b0, 8'h00, 8'h56}, '{8'h14,           1'b0, 8'h00, 8'h00}};

   assign hready = hreadyout;
   assign pc_in  = {2'b01, 1'b0, stb_n, 1'b0, ack_n, 2'b00};
   always #2.5 sys_clk = ~sys_clk;

   sph_strobed_port u_sph_strobed_port (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .pb_in(8'h00), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out),
      .pc_oe(pc_oe));
   sph_periph_model u_sph_periph_model (
      .sys_clk(sys_clk), .load_go(load_go), .load_byte(load_byte), .ack_dly(ack_dly),
      .armed(pb_oe === 8'hFF), .obf_n(pc_out[1]), .out_byte(pb_out), .stb_n(stb_n),
      .ack_n(ack_n), .data(pa_in), .got(got));

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 50);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 50);
      rd = hrdata;
      if (n >= 50) n_errors++;
   endtask : bus

   task automatic wait_pc(input int b, input logic v);
      int n;
      n = 0;
      while (pc_out[b] !== v && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : wait_pc

   // Strobe pulse is handed over as one cycle of load_go
   task automatic load(input logic [7:0] b);
      load_byte <= b;
      load_go   <= 1'b1;
      @(posedge sys_clk);
      load_go   <= 1'b0;
      wait_pc(5, 1'b1);
   endtask : load

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------
   initial begin
      #20000;
      n_errors++;
      tally_and_finish();
   end

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = `SPH_HSIZE_WORD;
      {load_go, load_byte, ack_dly, ob, n_errors, num_checks} = '0;
      repeat (12) @(posedge sys_clk);
      `CHK({pc_out[3:0], pc_oe, hreadyout}, {4'h0, 8'h2B, 1'b1})
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      foreach (rows[i]) begin
         bus(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) `CHK(rd, {24'h00_0000, rows[i].e})
      end
      `CHK({pa_oe, pb_oe, pc_oe}, 24'h00_FF2B)
      load(8'hA5);
      `CHK({pc_out[5], pc_out[3]}, 2'b10)
      wait_pc(3, 1'b1);
      `CHK(pc_out[3], 1'b1)
      bus(`SPH_ADDR_PORTA, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_00A5)
      `CHK({pc_out[5], pc_out[3]}, 2'b00)
      bus(`SPH_ADDR_BSR, 1'b1, 8'h08);
      load(8'h3C);
      // Strobe stays low three cycles, the interrupt would follow two edges after it ends
      repeat (6) @(posedge sys_clk);
      `CHK({pc_out[5], pc_out[4], pc_out[3]}, 3'b100)
      bus(`SPH_ADDR_PORTA, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_003C)
      // A write to an input port only updates its output register
      bus(`SPH_ADDR_PORTA, 1'b1, 8'h77);
      `CHK({pa_out, pc_out[5], hresp}, {8'h77, 1'b0, 1'b0})
      for (int k = 0; k < 2; k++) begin
         ob = k ? 8'h5A : 8'hC3;
         ack_dly <= k ? 4'h0 : 4'h6;
         bus(`SPH_ADDR_PORTB, 1'b1, ob);
         `CHK({pc_out[1], pc_out[0], pb_out}, {2'b00, ob})
         wait_pc(1, 1'b1);
         `CHK(pc_out[1], 1'b1)
         wait_pc(0, 1'b1);
         `CHK({pc_out[0], got}, {1'b1, ob})
      end
      // Mid-run reset must return flags, enables and control to their idle values
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      `CHK({pc_out[3:0], pc_oe, hreadyout}, {4'h0, 8'h2B, 1'b1})
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bus(`SPH_ADDR_CTRL, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_000B)
      tally_and_finish();
   end
endmodule : sph_strobed_port_tb
`default_nettype wire
